/* File: verilog/cls_stopwatch.sv */
// Summary of operation
// RULE_01 - Each channel has two start and two stop taps, chosen by control bits.
// RULE_02 - Only the selected channel is timed, start tap to stop tap.
// RULE_03 - Commas are control characters 0x3C, 0xBC or 0xFC only.
// RULE_04 - First start comma begins counting; later start commas are ignored.
// RULE_05 - First stop comma after start halts counting and freezes the result.
// RULE_06 - Result is a 20-bit count of measurement ticks, readable by software.
// RULE_07 - An interval beyond range reads as 0xFFFFF, never wrapping.
// RULE_08 - One result is held and not replaced until software reads it.
// RULE_09 - Result reads zero when no start comma was ever seen.
// RULE_10 - Manual mode starts and stops on the port address LSB pin level.
// RULE_11 - Fast tick is bit rate over 8, 4, 2 or 1 for the rate setting.
// RULE_12 - Result is accurate to one measurement tick either way.
// RULE_13 - A divider setting scales the measurement tick by 1, 2, 4 or 8.
// RULE_14 - Measurement ticks always come from the channel under test.
// RULE_15 - Alternatively the recovered byte clock of that channel is counted.
// RULE_16 - Software picks the fast tick only at standard radio serial rates.
// RULE_17 - Software divides the tick when intervals may exceed 682 microseconds.
// RULE_18 - Taps exclude the slow serializer and part of the synchroniser.
// RULE_19 - Running count adds one per enabled tick; reading the result re-arms.
`timescale 1ns/100ps
`include "cls_map.svh"

module cls_stopwatch
   import cls_pkg::*;
(
   input wire logic clock,
   input wire logic rstn,
   input wire logic ce,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire cls_tap_type [`CLS_NUM_CHAN-1:0][`CLS_NUM_TAP-1:0] tap,
   input wire logic [`CLS_NUM_CHAN-1:0] bit_tick,
   input wire logic [`CLS_NUM_CHAN-1:0] byte_tick,
   input wire logic port_address_lsb_pin
);

   // ============================================================
   // Tick mask helper
   function automatic logic [`CLS_PRE_WIDTH-1:0] cls_mask(input logic [1:0] code);
      logic [`CLS_PRE_WIDTH-1:0] m;
      m = `CLS_MASK_DIV1;
      case (code)
         2'b00: m = `CLS_MASK_DIV1;
         2'b01: m = `CLS_MASK_DIV2;
         2'b10: m = `CLS_MASK_DIV4;
         default: m = `CLS_MASK_DIV8;
      endcase
      return m;
   endfunction : cls_mask

   // ============================================================
   // State
   cls_ctrl_type ctrl;
   cls_state_type state;
   cls_state_type next_state;
   logic [`CLS_COUNT_WIDTH-1:0] count;
   logic [`CLS_COUNT_WIDTH-1:0] next_count;
   logic started;
   logic next_started;
   logic [`CLS_PRE_WIDTH-1:0] rate_cnt;
   logic [`CLS_PRE_WIDTH-1:0] div_cnt;
   logic pin_meta;
   logic pin_sync;
   logic wr_pend;
   logic [`CLS_ADDR_WIDTH-1:0] addr_q;

   // ============================================================
   // Comma detectors on every tap of both channels
   wire [`CLS_NUM_CHAN-1:0][`CLS_NUM_TAP-1:0] hit;

   genvar gc;
   genvar gt;
   generate
      for (gc = 0; gc < `CLS_NUM_CHAN; gc++) begin : g_chan
         for (gt = 0; gt < `CLS_NUM_TAP; gt++) begin : g_tap
            cls_comma_detect u_det (
               .clock(clock),
               .rstn(rstn),
               .ce(ce),
               .tap(tap[gc][gt]),
               .hit(hit[gc][gt])
            );
         end
      end
   endgenerate

   // ============================================================
   // Pin synchroniser
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         pin_meta <= 1'b0;
         pin_sync <= 1'b0;
      end else if (ce) begin
         pin_meta <= port_address_lsb_pin;
         pin_sync <= pin_meta;
      end
   end

   // ============================================================
   // Start and stop selection
   // The taps sit after the slow-side serializer and the channel
   // synchroniser front, so their delay is outside the measured span.
   wire [`CLS_NUM_TAP-1:0] chan_hit;
   wire start_comma;
   wire stop_comma;
   wire start_hit;
   wire stop_hit;
   wire [1:0] start_idx;
   wire [1:0] stop_idx;

   assign chan_hit = hit[ctrl.chan]; // [RULE_02]
   assign start_idx = {1'b0, ctrl.start_sel}; // [RULE_01] [RULE_18]
   assign stop_idx = 2'(`CLS_TAP_STOP_BASE) + {1'b0, ctrl.stop_sel}; // [RULE_01] [RULE_18]
   assign start_comma = chan_hit[start_idx];
   assign stop_comma = chan_hit[stop_idx];
   assign start_hit = ctrl.manual ? pin_sync : start_comma; // [RULE_10]
   assign stop_hit = ctrl.manual ? ~pin_sync : stop_comma; // [RULE_10]

   // ============================================================
   // Measurement tick
   wire sel_bit_tick;
   wire sel_byte_tick;
   wire hs_tick;
   wire base_tick;
   wire meas_tick;
   wire [`CLS_PRE_WIDTH-1:0] rate_mask;
   wire [`CLS_PRE_WIDTH-1:0] div_mask;

   assign sel_bit_tick = bit_tick[ctrl.chan]; // [RULE_14]
   assign sel_byte_tick = byte_tick[ctrl.chan]; // [RULE_14]
   assign rate_mask = cls_mask(~ctrl.rate); // [RULE_11]
   assign hs_tick = sel_bit_tick & ((rate_cnt & rate_mask) == rate_mask); // [RULE_11]
   assign base_tick = ctrl.byte_src ? sel_byte_tick : hs_tick; // [RULE_15]
   assign div_mask = cls_mask(ctrl.div); // [RULE_13]
   assign meas_tick = base_tick & ((div_cnt & div_mask) == div_mask); // [RULE_13]

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rate_cnt <= '0;
      end else if (ce && sel_bit_tick) begin
         rate_cnt <= rate_cnt + `CLS_PRE_ONE;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         div_cnt <= '0;
      end else if (ce && base_tick) begin
         div_cnt <= div_cnt + `CLS_PRE_ONE;
      end
   end

   // ============================================================
   // Bus decode
   wire accept;
   wire rd_accept;
   wire [`CLS_ADDR_WIDTH-1:0] acc_addr;
   wire rd_result;
   wire wr_ctrl;
   wire [31:0] rd_value;
   wire cls_status_type status;

   assign accept = hsel & htrans[1] & hready;
   assign rd_accept = accept & ~hwrite;
   assign acc_addr = haddr[`CLS_ADDR_WIDTH-1:0];
   assign rd_result = rd_accept & (acc_addr == `CLS_OFS_RESULT); // [RULE_19]
   assign wr_ctrl = wr_pend & (addr_q == `CLS_OFS_CTRL);

   assign status.running = (state == CLS_RUN);
   assign status.done = (state == CLS_DONE);
   assign status.started = started;
   assign status.saturated = (count == `CLS_COUNT_MAX);

   assign rd_value =
      (acc_addr == `CLS_OFS_CTRL) ? {`CLS_CTRL_PAD, ctrl} :
      (acc_addr == `CLS_OFS_RESULT) ? {`CLS_RESULT_PAD, count} : // [RULE_06]
      (acc_addr == `CLS_OFS_STATUS) ? {`CLS_STATUS_PAD, status} :
      `CLS_READ_ZERO;

   // ============================================================
   // Stopwatch state machine
   // A start or stop event that meets a result read in one cycle wins,
   // so no event is lost; a later read then returns the held count.
   wire start_event;
   wire stop_event;
   wire rearm;

   assign start_event = (state == CLS_IDLE) & ctrl.enable & start_hit;
   assign stop_event = (state == CLS_RUN) & stop_hit;
   assign rearm = rd_result & ~start_event & ~stop_event; // [RULE_19]

   always_comb begin
      next_state = state;
      next_count = count;
      next_started = started;
      case (state)
         CLS_IDLE: begin
            if (ctrl.enable && start_hit) begin
               next_state = CLS_RUN; // [RULE_04]
               next_count = `CLS_COUNT_ZERO;
               next_started = 1'b1;
            end
         end
         CLS_RUN: begin
            if (stop_hit) begin
               next_state = CLS_DONE; // [RULE_05]
            end else if (meas_tick && (count != `CLS_COUNT_MAX)) begin // [RULE_07]
               next_count = count + 20'h00001; // [RULE_19] [RULE_12]
            end
         end
         CLS_DONE: begin
            next_state = CLS_DONE; // [RULE_08]
         end
         default: begin
            next_state = CLS_IDLE;
         end
      endcase
      // A read consumes the held result and arms a fresh measurement.
      if (rearm) begin
         next_state = CLS_IDLE; // [RULE_19]
         next_count = `CLS_COUNT_ZERO; // [RULE_09]
         next_started = 1'b0;
      end
   end

   // Saturation holds the count at all ones once the range is used up.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state <= CLS_IDLE;
         count <= `CLS_COUNT_ZERO;
         started <= 1'b0;
      end else if (ce) begin
         state <= next_state;
         count <= next_count;
         started <= next_started;
      end
   end

   // ============================================================
   // Control register
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         ctrl <= cls_ctrl_type'(`CLS_CTRL_RESET);
      end else if (ce && wr_ctrl) begin
         ctrl <= cls_ctrl_type'(hwdata[`CLS_CTRL_WIDTH-1:0]); // [RULE_01]
      end
   end

   // ============================================================
   // AHB-Lite slave, zero wait states, always OKAY
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         wr_pend <= 1'b0;
         addr_q <= '0;
         hrdata <= `CLS_READ_ZERO;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else if (ce) begin
         wr_pend <= accept & hwrite;
         addr_q <= acc_addr;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         if (rd_accept) begin
            hrdata <= rd_value;
         end
      end
   end

endmodule : cls_stopwatch

/* File: verilog/cls_map.svh */
`ifndef CLS_MAP_SVH
`define CLS_MAP_SVH

// ============================================================
// Geometry
`define CLS_NUM_CHAN 2
`define CLS_NUM_TAP 4
`define CLS_TAP_STOP_BASE 2
`define CLS_COUNT_WIDTH 20
`define CLS_COUNT_MAX 20'hfffff
`define CLS_COUNT_ZERO 20'h00000

// ============================================================
// Register byte offsets
`define CLS_ADDR_WIDTH 8
`define CLS_OFS_CTRL 8'h00
`define CLS_OFS_RESULT 8'h04
`define CLS_OFS_STATUS 8'h08

// ============================================================
// Control and status layout
`define CLS_CTRL_WIDTH 10
`define CLS_CTRL_RESET 10'h000
`define CLS_CTRL_PAD 22'h000000
`define CLS_RESULT_PAD 12'h000
`define CLS_STATUS_WIDTH 4
`define CLS_STATUS_PAD 28'h0000000
`define CLS_READ_ZERO 32'h00000000

// ============================================================
// Comma characters
`define CLS_COMMA_K28_1 8'h3c
`define CLS_COMMA_K28_5 8'hbc
`define CLS_COMMA_K28_7 8'hfc

// ============================================================
// Prescale
`define CLS_PRE_WIDTH 3
`define CLS_PRE_ONE 3'h1
`define CLS_MASK_DIV1 3'h0
`define CLS_MASK_DIV2 3'h1
`define CLS_MASK_DIV4 3'h3
`define CLS_MASK_DIV8 3'h7

`endif

/* File: verilog/cls_pkg.sv */
package cls_pkg;

   typedef enum logic [1:0] {
      CLS_IDLE = 2'b00,
      CLS_RUN = 2'b01,
      CLS_DONE = 2'b10
   } cls_state_type;

   typedef enum logic [1:0] {
      CLS_RATE_FULL = 2'b00,
      CLS_RATE_HALF = 2'b01,
      CLS_RATE_QUARTER = 2'b10,
      CLS_RATE_EIGHTH = 2'b11
   } cls_rate_type;

   typedef struct packed {
      logic valid;
      logic ctrl;
      logic [7:0] data;
   } cls_tap_type;

   typedef struct packed {
      logic [1:0] div;
      cls_rate_type rate;
      logic byte_src;
      logic manual;
      logic stop_sel;
      logic start_sel;
      logic chan;
      logic enable;
   } cls_ctrl_type;

   typedef struct packed {
      logic saturated;
      logic started;
      logic done;
      logic running;
   } cls_status_type;

endpackage : cls_pkg

/* File: verilog/cls_comma_detect.sv */
`timescale 1ns/100ps
`include "cls_map.svh"

module cls_comma_detect
   import cls_pkg::*;
(
   input wire logic clock,
   input wire logic rstn,
   input wire logic ce,
   input wire cls_tap_type tap,
   output logic hit
);

   // ============================================================
   // Comma match
   wire is_comma;
   assign is_comma = tap.valid & tap.ctrl &
      ((tap.data == `CLS_COMMA_K28_1) |
       (tap.data == `CLS_COMMA_K28_5) |
       (tap.data == `CLS_COMMA_K28_7)); // [RULE_03]

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         hit <= 1'b0;
      end else if (ce) begin
         hit <= is_comma;
      end
   end

endmodule : cls_comma_detect

/* File: tb/cls_stopwatch_properties.sv */
`timescale 1ns/100ps
`include "cls_map.svh"

module cls_stopwatch_properties (
   input wire logic clock,
   input wire logic rstn,
   input wire logic ce,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp
);
   // ============================================================
   // Decoded bus requests
   wire logic req = hsel && htrans[1] && hready && ce;
   wire logic rd = req && !hwrite;
   wire logic rd_ctrl = rd && (haddr[7:0] == `CLS_OFS_CTRL);
   wire logic rd_res = rd && (haddr[7:0] == `CLS_OFS_RESULT);
   wire logic rd_st = rd && (haddr[7:0] == `CLS_OFS_STATUS);
   wire logic rd_bad = rd && !rd_ctrl && !rd_res && !rd_st;
   wire logic wr_ctrl = req && hwrite && (haddr[7:0] == `CLS_OFS_CTRL);

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rstn);

   sequence wr_then_rd_s;
      wr_ctrl ##1 1'b1 ##1 rd_ctrl;
   endsequence

   // ============================================================
   // Checks
   bus_ready_a: assert property (hreadyout) else $error("wait state inserted");
   bus_okay_a: assert property (!hresp) else $error("error response");
   unmapped_zero_a: assert property (rd_bad |=> hrdata == `CLS_READ_ZERO)
      else $error("unmapped read not zero");
   result_width_a: assert property (rd_res |=> hrdata[31:20] == `CLS_RESULT_PAD)
      else $error("result wider than twenty bits");
   status_excl_a: assert property (rd_st |=> !(hrdata[0] && hrdata[1]))
      else $error("running and done together");
   started_first_a: assert property (rd_st |=> !(hrdata[0] || hrdata[1]) || hrdata[2])
      else $error("run or done without start");
   sat_busy_a: assert property (rd_st |=> !hrdata[3] || hrdata[0] || hrdata[1])
      else $error("saturated while idle");
   status_pad_a: assert property (rd_st |=> hrdata[31:4] == `CLS_STATUS_PAD)
      else $error("status upper bits set");
   read_hold_a: assert property (!rd |=> $stable(hrdata))
      else $error("read data changed without a read");
   ctrl_back_a: assert property (wr_then_rd_s |=> hrdata == {`CLS_CTRL_PAD,
      $past(hwdata[9:0], 2)}) else $error("control readback differs");
endmodule : cls_stopwatch_properties

bind cls_stopwatch cls_stopwatch_properties u_props (.clock, .rstn, .ce, .hsel, .haddr,
   .htrans, .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp);

/* File: tb/cls_path_model.sv */
`timescale 1ns/100ps

module cls_path_model (
   input wire logic clock,
   input wire logic rstn,
   output logic [1:0] bit_tick,
   output logic [1:0] byte_tick
);
   // ============================================================
   // Channel tick sources
   logic [5:0] cnt;

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         cnt <= 6'h00;
      end else begin
         cnt <= (cnt == 6'h27) ? 6'h00 : cnt + 6'h01;
      end
   end

   // Channel 0 has a serial unit every cycle, channel 1 every other cycle.
   assign bit_tick = {cnt[0], 1'b1};
   // One byte clock pulse per twenty serial units of the same channel.
   assign byte_tick = {cnt == 6'h00, (cnt == 6'h00) || (cnt == 6'h14)};
endmodule : cls_path_model

/* File: tb/cls_stopwatch_tb_top.sv */
`timescale 1ns/100ps
`include "cls_map.svh"

module cls_stopwatch_tb_top
   import cls_pkg::*;
();
   logic clock = 1'b0;
   logic rstn = 1'b0;
   logic ce = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = '0;
   logic [1:0] htrans = 2'b00;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = '0;
   logic port_address_lsb_pin = 1'b0;
   cls_tap_type [1:0][3:0] tap = '0;
   wire logic [31:0] hrdata;
   wire logic hreadyout;
   wire logic [1:0] bit_tick;
   wire logic [1:0] byte_tick;
   logic [7:0] cm [3] = '{`CLS_COMMA_K28_1, `CLS_COMMA_K28_5, `CLS_COMMA_K28_7};
   logic [31:0] rv;
   int num_errors = 0;
   int n_tests = 0;
   int i;

   always #50 clock = ~clock;

   cls_stopwatch u_dut (.clock, .rstn, .ce, .hsel, .haddr, .htrans, .hwrite,
      .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp(), .tap,
      .bit_tick, .byte_tick, .port_address_lsb_pin);
   cls_path_model u_path (.clock, .rstn, .bit_tick, .byte_tick);

   // ============================================================
   // Bus and tap tasks
   task conclude;
      if (num_errors == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : conclude

   task chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
      n_tests++;
      if ((^got === 1'bx) || got < lo || got > hi) begin
         num_errors++;
         $display("ERROR %0t got %h exp %h", $time, got, lo);
      end
   endtask : chk

   task edge_wait;
      int n;
      for (n = 0; n < 20; n++) begin
         @(posedge clock);
         if (hreadyout === 1'b1) break;
      end
      if (n == 20) begin
         num_errors++;
         conclude();
      end
   endtask : edge_wait

   task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      htrans <= 2'b10;
      hwrite <= w;
      edge_wait();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      edge_wait();
      rv = hrdata;
   endtask : ahb

   task rd(input logic [7:0] a, input logic [31:0] lo, input logic [31:0] hi);
      ahb(1'b0, a, '0);
      chk(rv, lo, hi);
   endtask : rd

   task pulse(input int c, input int t, input logic [9:0] v);
      tap[c][t] <= v;
      @(posedge clock);
      tap <= '0;
      @(posedge clock);
   endtask : pulse

   function logic [31:0] cf(input logic [1:0] r, dv, input logic s, st, sp);
      return {22'h000000, dv, r, s, 1'b0, sp, st, 2'b11};
   endfunction : cf

   // Start, stray commas mid-run on the start tap and on unselected stop taps, then stop k cycles after start.
   task meas(input logic [31:0] cfg, input int k, input int ci);
      ahb(1'b1, `CLS_OFS_CTRL, cfg);
      rd(`CLS_OFS_CTRL, cfg, cfg);
      pulse(cfg[1], cfg[2], {2'b10, cm[ci]});
      pulse(cfg[1], cfg[2], {2'b01, cm[ci]});
      pulse(cfg[1], cfg[2], {2'b11, 8'hbd});
      pulse(cfg[1], cfg[2], {2'b11, cm[ci]});
      repeat (k / 2 - 2) @(posedge clock);
      tap[cfg[1]][cfg[2]] <= {2'b11, cm[ci]};
      tap[!cfg[1]][2 + cfg[3]] <= {2'b11, cm[ci]};
      tap[cfg[1]][3 - cfg[3]] <= {2'b11, cm[ci]};
      @(posedge clock);
      tap <= '0;
      repeat (k / 2 - 1) @(posedge clock);
      pulse(cfg[1], 2 + cfg[3], {2'b11, cm[ci]});
      repeat (4) @(posedge clock);
   endtask : meas

   // ============================================================
   // Main sequence
   // Intervals stay far below the undivided range at standard rates.
   initial begin
      repeat (2) @(posedge clock);
      rstn <= 1'b1;
      rd(`CLS_OFS_CTRL, 0, 0);
      rd(`CLS_OFS_RESULT, 0, 0);
      rd(`CLS_OFS_STATUS, 0, 0);
      rd(8'h0c, 0, 0);
      for (i = 0; i < 4; i++) begin
         meas(cf(i[1:0], 2'h0, 1'b0, i[0], i[1]), 128, i % 3);
         rd(`CLS_OFS_STATUS, 32'h6, 32'h6);
         rd(`CLS_OFS_RESULT, (64 >> (3 - i)) - 1, (64 >> (3 - i)) + 1);
      end
      for (i = 1; i < 4; i++) begin
         meas(cf(2'h3, i[1:0], 1'b0, 1'b1, 1'b1), 128, 1);
         rd(`CLS_OFS_RESULT, (64 >> i) - 1, (64 >> i) + 1);
      end
      meas(cf(2'h0, 2'h0, 1'b1, 1'b0, 1'b0), 400, 2);
      rd(`CLS_OFS_RESULT, 9, 11);
      // Channel 0 carries a serial unit every cycle, so the undivided count adds one tick per cycle.
      meas(cf(2'h3, 2'h0, 1'b0, 1'b1, 1'b0) & 32'h3fd, 40, 2);
      rd(`CLS_OFS_RESULT, 38, 40);
      meas(cf(2'h3, 2'h0, 1'b0, 1'b0, 1'b0), 40, 0);
      meas(cf(2'h3, 2'h0, 1'b0, 1'b0, 1'b0), 100, 0);
      rd(`CLS_OFS_RESULT, 19, 21);
      rd(`CLS_OFS_RESULT, 0, 0);
      meas(cf(2'h3, 2'h0, 1'b0, 1'b0, 1'b0) & 32'h3fe, 40, 1);
      rd(`CLS_OFS_RESULT, 0, 0);
      ahb(1'b1, `CLS_OFS_CTRL, cf(2'h3, 2'h0, 1'b0, 1'b0, 1'b0) | 32'h10);
      port_address_lsb_pin <= 1'b1;
      repeat (100) @(posedge clock);
      port_address_lsb_pin <= 1'b0;
      repeat (6) @(posedge clock);
      rd(`CLS_OFS_RESULT, 49, 51);
      // A manual run with the clock enable low for fifty cycles counts only enabled ticks.
      port_address_lsb_pin <= 1'b1;
      repeat (50) @(posedge clock);
      ce <= 1'b0;
      repeat (50) @(posedge clock);
      ce <= 1'b1;
      port_address_lsb_pin <= 1'b0;
      repeat (6) @(posedge clock);
      rd(`CLS_OFS_RESULT, 23, 26);
      conclude();
   end
endmodule : cls_stopwatch_tb_top
